/* File: design/lmr_device.sv */
// Purpose: device end, decodes register read/write and returns read bursts
// Assumes: controller keeps command spacing and issues NOPs when required
// Notes: data beats are one clk each; strobes toggle once per beat
`timescale 1ns/1ns
`include "lmr_map.svh"
module lmr_device #(
	parameter int TSI_CYC = `LMR_TTSI_MS * `LMR_CLK_KHZ
) (
	input wire logic clk,
	input wire logic resetn,
	lmr_if.dev_mp link,
	input wire logic bank_active,
	input wire logic [`LMR_TEMP_W-1:0] temp_sense,
	output logic mrw_valid,
	output logic [`LMR_MA_W-1:0] mrw_addr,
	output logic [`LMR_OP_W-1:0] mrw_data,
	output logic init_busy
);
	import lmr_pkg::*;

	localparam int IDX_W = $clog2(`LMR_ARRAY_N);
	localparam int TSI_W = $clog2(TSI_CYC + 1);
	localparam logic [1:0] LAST_BEAT = 2'(`LMR_BURST - 1);

	lmr_dev_state_t state_reg;
	lmr_dev_state_t state_next;
	logic [`LMR_CNT_W-1:0] cnt_reg;
	logic [`LMR_CNT_W-1:0] cnt_next;
	logic [1:0] beat_reg;
	logic [1:0] beat_next;
	logic drive_next;
	logic [`LMR_MA_W-1:0] addr_reg;
	logic [`LMR_OP_W-1:0] mode_reg [0:`LMR_ARRAY_N-1];
	logic [`LMR_TEMP_W-1:0] tsr_reg;
	logic [TSI_W-1:0] tsi_reg;
	logic cke_q_reg;
	logic [`LMR_DQ_W-1:0] dq_reg;
	logic dq_oe_reg;
	logic [`LMR_BYTES-1:0] dqs_reg;
	logic [`LMR_BYTES-1:0] dqs_n_reg;
	logic dqs_oe_reg;
	logic mrw_valid_reg;
	logic [`LMR_MA_W-1:0] mrw_addr_reg;
	logic [`LMR_OP_W-1:0] mrw_data_reg;
	logic init_busy_reg;

	////////////////////////////////////////////////////////////////////////
	// command decode
	wire cmd_sel = link.cke & ~link.cs_n;
	wire is_mrr = cmd_sel & (link.ca_r[3:0] == `LMR_CMD_MRR);
	wire is_mrw = cmd_sel & (link.ca_r[3:0] == `LMR_CMD_MRW);
	wire [`LMR_MA_W-1:0] cmd_ma = {link.ca_r[`LMR_CA_W-1:4], link.ca_f[1:0]};
	wire [`LMR_OP_W-1:0] cmd_op = link.ca_f[`LMR_CA_W-1:2];
	wire idle = state_reg == D_IDLE;
	// busy states swallow every command
	wire take_mrr = idle & is_mrr;
	wire take_mrw = idle & is_mrw & ~bank_active;
	wire take_rst = take_mrw & (cmd_ma == `LMR_MA_RESET);
	wire in_array = cmd_ma < `LMR_MA_W'(`LMR_ARRAY_N);
	wire wr_array = take_mrw & ~take_rst & in_array & (cmd_ma != `LMR_MA_TEMP);

	////////////////////////////////////////////////////////////////////////
	// read data selection
	wire is_cal_a = addr_reg == `LMR_MA_CAL_A;
	wire is_cal_b = addr_reg == `LMR_MA_CAL_B;
	wire is_cal = is_cal_a | is_cal_b;
	wire [3:0] cal_pat = is_cal_a ? `LMR_PAT_A : `LMR_PAT_B;
	wire addr_in_array = addr_reg < `LMR_MA_W'(`LMR_ARRAY_N);
	wire [`LMR_OP_W-1:0] array_val = addr_in_array ? mode_reg[addr_reg[IDX_W-1:0]] : '0;
	wire [`LMR_OP_W-1:0] rd_val = (addr_reg == `LMR_MA_TEMP) ? `LMR_OP_W'(tsr_reg) : array_val;
	wire [1:0] next_beat = (state_reg == D_BURST) ? beat_reg + 2'h1 : 2'h0;
	wire cal_bit = cal_pat[next_beat];
	wire [`LMR_DQ_W-1:0] cal_word = {`LMR_DQ_W{cal_bit}};
	wire [`LMR_DQ_W-1:0] reg_word = (next_beat == 2'h0) ? `LMR_DQ_W'(rd_val) : '0;
	wire [`LMR_DQ_W-1:0] beat_word = is_cal ? cal_word : reg_word;
	wire [`LMR_DQ_W-1:0] dq_next = drive_next ? beat_word : '0;
	wire [`LMR_BYTES-1:0] dqs_next = drive_next ? {`LMR_BYTES{~next_beat[0]}} : '0;
	wire [`LMR_BYTES-1:0] dqs_n_next = drive_next ? {`LMR_BYTES{next_beat[0]}} : '0;

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		beat_next = beat_reg;
		drive_next = 1'b0;
		unique case (state_reg)
			D_IDLE: begin
				if (take_rst) begin
					state_next = D_INIT;
					cnt_next = `LMR_CNT_W'(`LMR_TINIT4_CYC - 2);
				end else if (take_mrr) begin
					state_next = D_LAT;
					cnt_next = `LMR_CNT_W'(`LMR_RL - 1);
				end
			end
			D_LAT: begin
				if (cnt_reg == `LMR_CNT_W'(1)) begin
					state_next = D_BURST;
					beat_next = 2'h0;
					drive_next = 1'b1;
				end else begin
					cnt_next = cnt_reg - `LMR_CNT_W'(1);
				end
			end
			D_BURST: begin
				if (beat_reg == LAST_BEAT) begin
					state_next = D_IDLE;
				end else begin
					beat_next = beat_reg + 2'h1;
					drive_next = 1'b1;
				end
			end
			D_INIT: begin
				if (cnt_reg == '0) begin
					state_next = D_IDLE;
				end else begin
					cnt_next = cnt_reg - `LMR_CNT_W'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= D_IDLE;
			cnt_reg <= '0;
			beat_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			beat_reg <= beat_next;
		end
	end

	// address held for the whole burst
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_reg <= '0;
		end else if (take_mrr) begin
			addr_reg <= cmd_ma;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dq_reg <= '0;
			dq_oe_reg <= 1'b0;
			dqs_reg <= '0;
			dqs_n_reg <= '0;
			dqs_oe_reg <= 1'b0;
		end else begin
			dq_reg <= dq_next;
			dq_oe_reg <= drive_next;
			dqs_reg <= dqs_next;
			dqs_n_reg <= dqs_n_next;
			dqs_oe_reg <= drive_next;
		end
	end

	assign link.dq_dev = dq_reg;
	assign link.dq_oe = dq_oe_reg;
	assign link.dqs_dev = dqs_reg;
	assign link.dqs_n_dev = dqs_n_reg;
	assign link.dqs_oe = dqs_oe_reg;

	////////////////////////////////////////////////////////////////////////
	// writable mode registers
	genvar gi;
	generate
		for (gi = 0; gi < `LMR_ARRAY_N; gi++) begin : g_mode
			wire hit = wr_array & (cmd_ma[IDX_W-1:0] == IDX_W'(gi));
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					mode_reg[gi] <= `LMR_REG_DEFAULT;
				end else if (take_rst) begin
					mode_reg[gi] <= `LMR_REG_DEFAULT;
				end else if (hit) begin
					mode_reg[gi] <= cmd_op;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// temperature status refresh
	wire cke_rise = link.cke & ~cke_q_reg;
	wire tsi_due = (tsi_reg == '0) | cke_rise;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cke_q_reg <= 1'b0;
			tsr_reg <= '0;
			tsi_reg <= '0;
		end else begin
			cke_q_reg <= link.cke;
			if (tsi_due) begin
				tsr_reg <= temp_sense;
				tsi_reg <= TSI_W'(TSI_CYC - 1);
			end else begin
				tsi_reg <= tsi_reg - TSI_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// user side
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mrw_valid_reg <= 1'b0;
			mrw_addr_reg <= '0;
			mrw_data_reg <= '0;
			init_busy_reg <= 1'b0;
		end else begin
			mrw_valid_reg <= take_mrw;
			init_busy_reg <= state_next == D_INIT;
			if (take_mrw) begin
				mrw_addr_reg <= cmd_ma;
				mrw_data_reg <= cmd_op;
			end
		end
	end

	assign mrw_valid = mrw_valid_reg;
	assign mrw_addr = mrw_addr_reg;
	assign mrw_data = mrw_data_reg;
	assign init_busy = init_busy_reg;
endmodule

/* File: design/lmr_map.svh */
// Purpose: named constants for the mode register access ends
// Assumes: one SDR beat per clk cycle stands for one data beat
// Notes: header only, no logic
`ifndef LMR_MAP_SVH
`define LMR_MAP_SVH
`define LMR_CA_W 10
`define LMR_DQ_W 16
`define LMR_BYTES 2
`define LMR_MA_W 8
`define LMR_OP_W 8
`define LMR_TEMP_W 3
`define LMR_BL_W 5
`define LMR_HOLD_W 6
`define LMR_CNT_W 8
`define LMR_BURST 4
`define LMR_CMD_MRR 4'h8
`define LMR_CMD_MRW 4'h0
`define LMR_MA_TEMP 8'h04
`define LMR_MA_CAL_A 8'h20
`define LMR_MA_CAL_B 8'h28
`define LMR_MA_RESET 8'h3f
`define LMR_PAT_A 4'h5
`define LMR_PAT_B 4'hc
`define LMR_ARRAY_N 16
`define LMR_REG_DEFAULT 8'h00
`define LMR_RL 3
`define LMR_WL 1
`define LMR_TCK_NS 8
`define LMR_CLK_KHZ 125000
`define LMR_TDQSCK_MAX_NS 5
`define LMR_TWTR_NS 8
`define LMR_DQSCK_CYC ((`LMR_TDQSCK_MAX_NS + `LMR_TCK_NS - 1) / `LMR_TCK_NS)
`define LMR_WTR_CYC ((`LMR_TWTR_NS + `LMR_TCK_NS - 1) / `LMR_TCK_NS)
`define LMR_TMRR_CYC 2
`define LMR_TMRW_CYC 5
`define LMR_TINIT4_CYC 8
`define LMR_TTSI_MS 32
`define LMR_MRR_TO_MRW (`LMR_RL + `LMR_DQSCK_CYC + `LMR_BURST / 2 + 1)
`define LMR_MRR_TO_WR (`LMR_MRR_TO_MRW + `LMR_WL)
`define LMR_WR_TO_MRR (`LMR_WL + 1 + `LMR_WTR_CYC)
`endif

/* File: design/lmr_pkg.sv */
// Purpose: shared types of the mode register access ends
// Assumes: nothing
// Notes: constants live in lmr_map.svh
package lmr_pkg;
	typedef enum logic [1:0] {LMR_REQ_READ, LMR_REQ_WRITE, LMR_REQ_RESET} lmr_req_t;
	typedef enum logic [1:0] {D_IDLE, D_LAT, D_BURST, D_INIT} lmr_dev_state_t;
	typedef enum logic [1:0] {H_IDLE, H_READ, H_MRW, H_INIT} lmr_host_state_t;
endpackage

/* File: design/lmr_if.sv */
// Purpose: command/address and data link between controller and device
// Assumes: single clock, pins sampled synchronously
// Notes: undriven data wires resolve to zero
`timescale 1ns/1ns
`include "lmr_map.svh"
interface lmr_if;
	logic cke;
	logic cs_n;
	logic [`LMR_CA_W-1:0] ca_r;
	logic [`LMR_CA_W-1:0] ca_f;
	logic [`LMR_DQ_W-1:0] dq_dev;
	logic dq_oe;
	logic [`LMR_BYTES-1:0] dqs_dev;
	logic [`LMR_BYTES-1:0] dqs_n_dev;
	logic dqs_oe;
	logic [`LMR_DQ_W-1:0] dq_bus;
	logic [`LMR_BYTES-1:0] dqs_bus;
	logic [`LMR_BYTES-1:0] dqs_n_bus;

	assign dq_bus = dq_oe ? dq_dev : '0;
	assign dqs_bus = dqs_oe ? dqs_dev : '0;
	assign dqs_n_bus = dqs_oe ? dqs_n_dev : '0;

	modport dev_mp (
		input cke, cs_n, ca_r, ca_f,
		output dq_dev, dq_oe, dqs_dev, dqs_n_dev, dqs_oe
	);
	modport host_mp (
		output cke, cs_n, ca_r, ca_f,
		input dq_bus, dqs_bus, dqs_n_bus
	);
endinterface

/* File: design/lmr_host.sv */
// Purpose: controller end, issues register accesses and keeps their spacing
// Assumes: ext_read/ext_write flag READ/WRITE commands issued elsewhere
// Notes: deselect stands for NOP between commands
`timescale 1ns/1ns
`include "lmr_map.svh"
module lmr_host (
	input wire logic clk,
	input wire logic resetn,
	lmr_if.host_mp link,
	input wire logic req_valid,
	input wire lmr_pkg::lmr_req_t req_kind,
	input wire logic [`LMR_MA_W-1:0] req_addr,
	input wire logic [`LMR_OP_W-1:0] req_data,
	input wire logic bank_active,
	input wire logic ext_read,
	input wire logic ext_write,
	input wire logic [`LMR_BL_W-1:0] ext_bl,
	output logic req_ready,
	output logic req_taken,
	output logic req_err,
	output logic rd_valid,
	output logic [`LMR_OP_W-1:0] rd_data,
	output logic [`LMR_BURST-1:0] rd_pattern,
	output logic write_block
);
	import lmr_pkg::*;

	localparam logic [`LMR_CNT_W-1:0] RD_FIRST = `LMR_CNT_W'(`LMR_RL);
	localparam logic [`LMR_CNT_W-1:0] RD_LAST = `LMR_CNT_W'(`LMR_RL + `LMR_BURST - 1);

	lmr_host_state_t state_reg;
	lmr_host_state_t state_next;
	logic [`LMR_CNT_W-1:0] hcnt_reg;
	logic [`LMR_HOLD_W-1:0] mrr_hold_reg;
	logic [`LMR_HOLD_W-1:0] mrw_hold_reg;
	logic [`LMR_HOLD_W-1:0] wr_hold_reg;
	logic cke_reg;
	logic cs_n_reg;
	logic [`LMR_CA_W-1:0] ca_r_reg;
	logic [`LMR_CA_W-1:0] ca_f_reg;
	logic ready_reg;
	logic taken_reg;
	logic err_reg;
	logic rdv_reg;
	logic [`LMR_OP_W-1:0] rdd_reg;
	logic [`LMR_BURST-1:0] pat_reg;
	logic wb_reg;

	////////////////////////////////////////////////////////////////////////
	// request check
	wire is_rd = req_kind == LMR_REQ_READ;
	wire is_wr = req_kind == LMR_REQ_WRITE;
	wire is_rs = req_kind == LMR_REQ_RESET;
	wire cal_addr = (req_addr == `LMR_MA_CAL_A) | (req_addr == `LMR_MA_CAL_B);
	wire forbid = ~(is_rd | is_wr | is_rs) | (bank_active & (is_wr | is_rs | (is_rd & cal_addr)));
	wire blocked = is_rd ? (mrr_hold_reg != '0) : (mrw_hold_reg != '0);
	wire accept = req_valid & ready_reg & ~blocked;
	wire issue = accept & ~forbid;
	wire [`LMR_MA_W-1:0] ma = is_rs ? `LMR_MA_RESET : req_addr;
	wire [3:0] opc = is_rd ? `LMR_CMD_MRR : `LMR_CMD_MRW;
	wire [`LMR_OP_W-1:0] op = is_wr ? req_data : '0;
	wire [`LMR_CA_W-1:0] ca_r_next = issue ? {ma[`LMR_MA_W-1:2], opc} : '0;
	wire [`LMR_CA_W-1:0] ca_f_next = issue ? {op, ma[1:0]} : '0;

	////////////////////////////////////////////////////////////////////////
	// spacing counters, saturating down
	wire [`LMR_HOLD_W-1:0] mrr_dec = (mrr_hold_reg == '0) ? '0 : mrr_hold_reg - `LMR_HOLD_W'(1);
	wire [`LMR_HOLD_W-1:0] mrw_dec = (mrw_hold_reg == '0) ? '0 : mrw_hold_reg - `LMR_HOLD_W'(1);
	wire [`LMR_HOLD_W-1:0] wr_dec = (wr_hold_reg == '0) ? '0 : wr_hold_reg - `LMR_HOLD_W'(1);
	wire [`LMR_HOLD_W-1:0] rd_gap = `LMR_HOLD_W'(ext_bl >> 1);
	wire [`LMR_HOLD_W-1:0] wr_gap = `LMR_HOLD_W'(`LMR_WR_TO_MRR) + rd_gap;
	wire [`LMR_HOLD_W-1:0] gap = ext_write ? wr_gap : rd_gap;
	wire ext_any = ext_read | ext_write;
	wire [`LMR_HOLD_W-1:0] mrr_next = (ext_any & (gap > mrr_dec)) ? gap : mrr_dec;
	wire rd_issue = issue & is_rd;
	wire [`LMR_HOLD_W-1:0] mrw_next = rd_issue ? `LMR_HOLD_W'(`LMR_MRR_TO_MRW) : mrw_dec;
	wire [`LMR_HOLD_W-1:0] wr_next = rd_issue ? `LMR_HOLD_W'(`LMR_MRR_TO_WR) : wr_dec;

	////////////////////////////////////////////////////////////////////////
	// sequencer
	wire cap = (state_reg == H_READ) & (hcnt_reg >= RD_FIRST);
	wire [1:0] cap_beat = 2'(hcnt_reg - RD_FIRST);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			H_IDLE: begin
				if (issue) begin
					if (is_rd) begin
						state_next = H_READ;
					end else if (is_wr) begin
						state_next = H_MRW;
					end else begin
						state_next = H_INIT;
					end
				end
			end
			H_READ: begin
				if (hcnt_reg == RD_LAST) begin
					state_next = H_IDLE;
				end
			end
			H_MRW: begin
				if (hcnt_reg == `LMR_CNT_W'(`LMR_TMRW_CYC - 2)) begin
					state_next = H_IDLE;
				end
			end
			H_INIT: begin
				if (hcnt_reg == `LMR_CNT_W'(`LMR_TINIT4_CYC - 2)) begin
					state_next = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= H_IDLE;
			hcnt_reg <= '0;
			mrr_hold_reg <= '0;
			mrw_hold_reg <= '0;
			wr_hold_reg <= '0;
		end else begin
			state_reg <= state_next;
			hcnt_reg <= (state_reg == H_IDLE) ? '0 : hcnt_reg + `LMR_CNT_W'(1);
			mrr_hold_reg <= mrr_next;
			mrw_hold_reg <= mrw_next;
			wr_hold_reg <= wr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pins and user outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cke_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			ca_r_reg <= '0;
			ca_f_reg <= '0;
			ready_reg <= 1'b0;
			taken_reg <= 1'b0;
			err_reg <= 1'b0;
			rdv_reg <= 1'b0;
			rdd_reg <= '0;
			pat_reg <= '0;
			wb_reg <= 1'b0;
		end else begin
			cke_reg <= 1'b1;
			cs_n_reg <= ~issue;
			ca_r_reg <= ca_r_next;
			ca_f_reg <= ca_f_next;
			ready_reg <= state_next == H_IDLE;
			taken_reg <= accept;
			err_reg <= accept & forbid;
			rdv_reg <= cap & (hcnt_reg == RD_LAST);
			wb_reg <= wr_next != '0;
			if (cap & (hcnt_reg == RD_FIRST)) begin
				rdd_reg <= link.dq_bus[`LMR_OP_W-1:0];
			end
			if (cap) begin
				pat_reg[cap_beat] <= link.dq_bus[0];
			end
		end
	end

	assign link.cke = cke_reg;
	assign link.cs_n = cs_n_reg;
	assign link.ca_r = ca_r_reg;
	assign link.ca_f = ca_f_reg;
	assign req_ready = ready_reg;
	assign req_taken = taken_reg;
	assign req_err = err_reg;
	assign rd_valid = rdv_reg;
	assign rd_data = rdd_reg;
	assign rd_pattern = pat_reg;
	assign write_block = wb_reg;
endmodule

/* File: testbench/lmr_link_asserts.sv */
// Purpose: concurrent checks on the link between the two mode register ends
// Assumes: both ends are the design modules, controller keeps spacing
// Notes: instanced beside the interface, no bind
`timescale 1ns/1ns
`include "lmr_map.svh"
module lmr_link_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic [`LMR_CA_W-1:0] ca_r,
	input wire logic [`LMR_CA_W-1:0] ca_f,
	input wire logic [`LMR_DQ_W-1:0] dq_dev,
	input wire logic dq_oe,
	input wire logic [`LMR_BYTES-1:0] dqs_dev,
	input wire logic [`LMR_BYTES-1:0] dqs_n_dev,
	input wire logic dqs_oe
);
	wire is_cmd = !cs_n && cke;
	wire is_rd = is_cmd && ca_r[3:0] == `LMR_CMD_MRR;
	wire is_wr = is_cmd && ca_r[3:0] == `LMR_CMD_MRW;
	wire [7:0] cmd_ma = {ca_r[9:4], ca_f[1:0]};
	wire rd_cal_a = is_rd && cmd_ma == `LMR_MA_CAL_A;
	wire rd_cal_b = is_rd && cmd_ma == `LMR_MA_CAL_B;
	wire wr_rst = is_wr && cmd_ma == `LMR_MA_RESET;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////////////////////
	a_read_burst: assert property (is_rd |-> ##3 dq_oe [*4] ##1 !dq_oe)
		else $error("read burst timing wrong");
	a_oe_cause: assert property ($rose(dq_oe) |-> $past(is_rd, 3))
		else $error("data driven without read");
	a_strobe_pair: assert property (dqs_oe |-> dq_oe && dqs_n_dev == ~dqs_dev)
		else $error("strobe pair not complementary");
	a_strobe_toggle: assert property (dqs_oe && $past(dqs_oe) |-> dqs_dev == ~$past(dqs_dev))
		else $error("strobe did not toggle");
	a_cal_a_beats: assert property (rd_cal_a |-> ##3 dq_dev == 16'hffff ##1 dq_dev == 16'h0000
		##1 dq_dev == 16'hffff ##1 dq_dev == 16'h0000)
		else $error("pattern a wrong");
	a_cal_b_beats: assert property (rd_cal_b |-> ##3 dq_dev == 16'h0000 ##1 dq_dev == 16'h0000
		##1 dq_dev == 16'hffff ##1 dq_dev == 16'hffff)
		else $error("pattern b wrong");
	a_plain_lanes: assert property (is_rd && !rd_cal_a && !rd_cal_b |-> ##3 dq_dev[15:8] == 8'h00
		##1 (dq_dev == 16'h0000) [*3])
		else $error("undefined lanes not at defined level");
	a_mrr_nop: assert property (is_rd |=> cs_n [*6])
		else $error("command during read period");
	a_mrw_nop: assert property (is_wr && !wr_rst |=> cs_n [*4])
		else $error("command during write period");
	a_reset_nop: assert property (wr_rst |=> cs_n [*7])
		else $error("command during init period");
	a_cke_held: assert property ($past(resetn) |-> cke)
		else $error("clock enable dropped");
endmodule

/* File: testbench/tb_lpddr2_mode_register_access.sv */
// Purpose: self-checking bench for controller and device ends joined by the link
// Assumes: TSI_CYC shortened to 16
// Notes: table rows first, then bank, temperature, spacing and reset cases
`timescale 1ns/1ns
`include "lmr_map.svh"
module tb_lpddr2_mode_register_access;
	import lmr_pkg::*;
	typedef struct packed {lmr_req_t kind; logic [7:0] addr; logic [7:0] data; logic err; logic [7:0] rdat;
		logic [3:0] pat;} lmr_row_t;
	localparam lmr_row_t ROWS [10] = '{
		'{LMR_REQ_WRITE, 8'h05, 8'ha5, 1'b0, 8'h00, 4'h0},
		'{LMR_REQ_WRITE, 8'h0f, 8'h3c, 1'b0, 8'h00, 4'h0},
		'{LMR_REQ_READ, 8'h05, 8'h00, 1'b0, 8'ha5, 4'h1},
		'{LMR_REQ_READ, 8'h0f, 8'h00, 1'b0, 8'h3c, 4'h0},
		'{LMR_REQ_WRITE, 8'h04, 8'hff, 1'b0, 8'h00, 4'h0},
		'{LMR_REQ_READ, 8'h04, 8'h00, 1'b0, 8'h05, 4'h1},
		'{LMR_REQ_READ, 8'h20, 8'h00, 1'b0, 8'hff, `LMR_PAT_A},
		'{LMR_REQ_READ, 8'h28, 8'h00, 1'b0, 8'h00, `LMR_PAT_B},
		'{LMR_REQ_WRITE, 8'h30, 8'h77, 1'b0, 8'h00, 4'h0},
		'{LMR_REQ_READ, 8'h30, 8'h00, 1'b0, 8'h00, 4'h0}};
	logic clk, resetn, bank_active, req_valid, ext_read, ext_write;
	logic [2:0] temp_sense;
	lmr_req_t req_kind;
	logic [7:0] req_addr, req_data, mrw_addr, mrw_data, rd_data;
	logic [4:0] ext_bl;
	logic [3:0] rd_pattern;
	logic mrw_valid, init_busy, req_ready, req_taken, req_err, rd_valid, write_block;
	int n_fail, cmp_count, n;

	lmr_if lmr_if_inst ();
	lmr_device #(.TSI_CYC(16)) lmr_device_inst (.clk(clk), .resetn(resetn), .link(lmr_if_inst),
		.bank_active(bank_active), .temp_sense(temp_sense), .mrw_valid(mrw_valid), .mrw_addr(mrw_addr),
		.mrw_data(mrw_data), .init_busy(init_busy));
	lmr_host lmr_host_inst (.clk(clk), .resetn(resetn), .link(lmr_if_inst), .req_valid(req_valid),
		.req_kind(req_kind), .req_addr(req_addr), .req_data(req_data), .bank_active(bank_active),
		.ext_read(ext_read), .ext_write(ext_write), .ext_bl(ext_bl), .req_ready(req_ready), .req_taken(req_taken),
		.req_err(req_err), .rd_valid(rd_valid), .rd_data(rd_data), .rd_pattern(rd_pattern),
		.write_block(write_block));
	lmr_link_asserts lmr_link_asserts_inst (.clk(clk), .resetn(resetn), .cke(lmr_if_inst.cke),
		.cs_n(lmr_if_inst.cs_n), .ca_r(lmr_if_inst.ca_r), .ca_f(lmr_if_inst.ca_f), .dq_dev(lmr_if_inst.dq_dev),
		.dq_oe(lmr_if_inst.dq_oe), .dqs_dev(lmr_if_inst.dqs_dev), .dqs_n_dev(lmr_if_inst.dqs_n_dev),
		.dqs_oe(lmr_if_inst.dqs_oe));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step_until(ref logic sig, input int lim, output int k);
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (sig !== 1'b1 && k < lim);
		if (k >= lim) begin
			n_fail++;
			$display("ERROR wait expected %h seen %h", 1'b1, sig);
			conclude();
		end
	endtask

	task automatic issue(input lmr_req_t kind, input logic [7:0] addr, input logic [7:0] data, input logic err,
		input logic [7:0] rdat, input logic [3:0] pat);
		int k;
		req_kind = kind;
		req_addr = addr;
		req_data = data;
		req_valid = 1'b1;
		step_until(req_taken, 40, k);
		req_valid = 1'b0;
		check("req_err", req_err, err);
		if (err || kind == LMR_REQ_WRITE || kind == LMR_REQ_RESET) begin
			@(posedge clk);
			#1;
			check("mrw_valid", mrw_valid, !err);
			if (!err) begin
				check("mrw_addr", mrw_addr, addr);
				check("mrw_data", mrw_data, data);
			end
		end else begin
			step_until(rd_valid, 20, k);
			check("rd_latency", k, `LMR_RL + 4);
			check("rd_data", rd_data, rdat);
			check("rd_pattern", rd_pattern, pat);
			check("write_block", write_block, 1'b1);
			@(posedge clk);
			#1;
			check("write_block_end", write_block, 1'b0);
		end
		$display("done kind %0d addr %h", kind, addr);
	endtask

	task automatic spacing(input logic wr, input logic [4:0] bl, input int min_gap);
		int k;
		ext_write = wr;
		ext_read = !wr;
		ext_bl = bl;
		@(posedge clk);
		#1;
		ext_write = 1'b0;
		ext_read = 1'b0;
		req_kind = LMR_REQ_READ;
		req_addr = 8'h05;
		req_valid = 1'b1;
		k = 1;
		while (lmr_if_inst.cs_n !== 1'b0 && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k >= 40) begin
			n_fail++;
			$display("ERROR spacing_wait expected %h seen %h", 1'b0, lmr_if_inst.cs_n);
			conclude();
		end
		req_valid = 1'b0;
		check("gap_ok", k >= min_gap, 1'b1);
		step_until(rd_valid, 20, k);
		$display("done spacing wr %0d bl %0d", wr, bl);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		n_fail = 0;
		cmp_count = 0;
		resetn = 1'b0;
		bank_active = 1'b0;
		req_valid = 1'b0;
		ext_read = 1'b0;
		ext_write = 1'b0;
		ext_bl = 5'h04;
		temp_sense = 3'h5;
		req_kind = LMR_REQ_READ;
		req_addr = 8'h00;
		req_data = 8'h00;
		repeat (4) @(posedge clk);
		#1;
		check("rst_cs_n", lmr_if_inst.cs_n, 1'b1);
		check("rst_dq_oe", lmr_if_inst.dq_oe, 1'b0);
		check("rst_init_busy", init_busy, 1'b0);
		check("rst_ready", req_ready, 1'b0);
		resetn = 1'b1;
		@(posedge clk);
		#1;
		check("cke", lmr_if_inst.cke, 1'b1);
		for (int i = 0; i < 10; i++) begin
			issue(ROWS[i].kind, ROWS[i].addr, ROWS[i].data, ROWS[i].err, ROWS[i].rdat, ROWS[i].pat);
		end
		bank_active = 1'b1;
		issue(LMR_REQ_WRITE, 8'h05, 8'h11, 1'b1, 8'h00, 4'h0);
		issue(LMR_REQ_RESET, 8'h3f, 8'h00, 1'b1, 8'h00, 4'h0);
		issue(LMR_REQ_READ, 8'h20, 8'h00, 1'b1, 8'h00, 4'h0);
		issue(LMR_REQ_READ, 8'h05, 8'h00, 1'b0, 8'ha5, 4'h1);
		bank_active = 1'b0;
		issue(lmr_req_t'(2'h3), 8'h05, 8'h00, 1'b1, 8'h00, 4'h0);
		temp_sense = 3'h2;
		repeat (20) @(posedge clk);
		#1;
		issue(LMR_REQ_READ, 8'h04, 8'h00, 1'b0, 8'h02, 4'h0);
		spacing(1'b1, 5'h04, `LMR_WL + 1 + 2 + `LMR_WTR_CYC);
		spacing(1'b1, 5'h02, `LMR_WL + 1 + 1 + `LMR_WTR_CYC);
		spacing(1'b0, 5'h08, 4);
		issue(LMR_REQ_RESET, 8'h3f, 8'h00, 1'b0, 8'h00, 4'h0);
		n = 0;
		while (init_busy === 1'b1 && n < 20) begin
			n++;
			@(posedge clk);
			#1;
		end
		check("init_cycles", n, `LMR_TINIT4_CYC - 1);
		issue(LMR_REQ_READ, 8'h05, 8'h00, 1'b0, `LMR_REG_DEFAULT, 4'h0);
		conclude();
	end
endmodule
